// >>> hmt_pkg.sv
package hmt_pkg;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_CMD = 8'h21;
	localparam logic [7:0] ADDR_MODE = 8'h22;
	localparam logic [7:0] ADDR_TIMER = 8'h23;
	localparam logic [7:0] ADDR_EXT = 8'h24;
	localparam logic [7:0] ADDR_TERM = 8'h30;
	localparam int CMD_STI = 4;
	localparam int MODE_FMS_HI = 7;
	localparam int MODE_FMS_LO = 5;
	localparam int MODE_TMD = 4;
	localparam int MODE_RAC = 3;
	localparam int TIM_CNT_HI = 7;
	localparam int TIM_CNT_LO = 5;
	localparam int TIM_VAL_HI = 4;
	localparam int STAT_TIN = 3;
	localparam int STAT_EXI = 0;
	localparam int TERM_TSF = 0;
	localparam int TERM_TLP = 1;
	localparam int TERM_WDA = 2;
	localparam int TERM_WDB = 3;
	localparam int EX_XMR = 7;
	localparam int EX_XDU = 6;
	localparam int EX_PCE = 5;
	localparam int EX_RFO = 4;
	localparam int EX_SOV = 3;
	localparam int EX_MOS = 2;
	localparam int EX_SAW = 1;
	localparam int EX_WOV = 0;
	localparam logic [7:0] SVC_GROUP = 8'hfc;
	localparam logic [7:0] SVC_MASK = 8'hfd;
	localparam logic [7:0] EP_GROUP = 8'hff;
	localparam logic [2:0] CNT_UNLIMITED = 3'h7;
	localparam logic [7:0] COLLISION_BYTES = 8'h20;
	localparam int TEST_UNIT_DCLK = 512;
	localparam int EXT_UNIT_DCLK = 16348;
	localparam int BASE_TIME_NS = 64000000;
	localparam int DCLK_NS = 160;
	localparam int NORMAL_UNIT_DCLK = BASE_TIME_NS / DCLK_NS;
	typedef enum logic [2:0] {
		FM_AUTO1 = 3'b000,
		FM_AUTO2 = 3'b001,
		FM_NAUTO1 = 3'b010,
		FM_NAUTO2 = 3'b011,
		FM_RSVD = 3'b100,
		FM_TRANS1 = 3'b101,
		FM_TRANS2 = 3'b110,
		FM_TRANS3 = 3'b111
	} hmt_fmode_t;
	typedef enum logic [1:0] {
		TM_IDLE = 2'b00,
		TM_LONG = 2'b01,
		TM_BASE = 2'b10
	} hmt_tstate_t;
	typedef struct packed {
		logic iframe_start;
		logic nak;
		logic ack;
		logic collision;
		logic underrun;
		logic [7:0] byte_count;
	} hmt_tx_ev_t;
	typedef struct packed {
		logic rnr;
		logic nr_bad;
		logic s_info;
		logic i_not_cmd;
		logic s_undef;
		logic frame_lost;
	} hmt_rx_ev_t;
	typedef struct packed {
		logic [7:0] endpoint_id_first;
		logic [7:0] endpoint_id_second;
		logic [7:0] service_id_first;
		logic [7:0] service_id_second;
	} hmt_ids_t;
endpackage

// >>> hmt_ctrl.sv
`timescale 1ns/100ps
// Behaviour
// - Mode 000: auto, one-byte address vs both endpoints, own first endpoint.
// - Mode 001: auto, two-byte address, own first service/endpoint pair.
// - 010/011 non-auto; 100 reserved; 101 low, 110 all, 111 high byte.
// - Service group FC/FE matches first byte besides programmed services.
// - Endpoint group FF matches endpoint byte besides programmed endpoints.
// - External timer: start command starts, timer register write stops.
// - Internal timer supervises auto-mode timeouts and retries.
// - Receiver enabled only while receiver activate bit is one.
// - Internal: poll per base period expiry up to retry count, then irq.
// - Internal auto-mode timer starts on I-frame send or RNR reception.
// - Internal timer stops on irq, register write, or acknowledgement.
// - Retry count up to 6; 7 means unlimited retries.
// - External: irq after 16348 times count data clocks plus base period.
// - External with count 7: irq after every base period, repeating.
// - Base period (value+1)*0.064 s, or 512*(value+1) clocks in test.
// - Repeat flag on auto-mode negative ack or late bus collision.
// - Underrun aborts frame with seven ones and sets underrun flag.
// - Repeat or underrun blocks transmissions until flags register read.
// - Auto-mode protocol errors set protocol error flag.
// - Frame lost on full receive queue is discarded, flag set.
// - Terminal functions on: wake pin falling edge sets wake flag.
// - Terminal functions on: missed watchdog kick sets flag, resets.
// - Any extended flag sets summary bit; only flags read clears it.
// - Start command starts timer; internal mode also sends a poll.
module hmt_ctrl #(
	parameter int NORMAL_DCLK = hmt_pkg::NORMAL_UNIT_DCLK,
	parameter int WDOG_CYCLES = 1048576
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_data_clock,
	input wire logic i_external_wake_pin,
	input wire hmt_pkg::hmt_tx_ev_t i_tx_ev,
	input wire hmt_pkg::hmt_rx_ev_t i_rx_ev,
	input wire logic i_sync_transfer_overflow,
	input wire logic i_monitor_change,
	input wire hmt_pkg::hmt_ids_t i_ids,
	input wire logic [7:0] i_addr_hi,
	input wire logic [7:0] i_addr_lo,
	output logic o_addr_accept,
	output logic o_addr_own,
	output logic o_auto_mode,
	output logic o_rx_enable,
	output logic o_tx_blocked,
	output logic o_send_abort,
	output logic o_discard_frame,
	output logic o_poll_cmd,
	output logic o_timer_expiry_irq,
	output logic o_extended_summary_flag,
	output logic o_wdog_reset
);
	localparam int WW = $clog2(WDOG_CYCLES + 1);
	logic [7:0] mode_reg, timer_reg, term_reg, ext_flags, next_rdata;
	logic [7:0] next_mode, next_timer, next_term, next_flags, flag_set;
	logic summary, next_summary, tin_flag, next_tin_flag;
	logic blocked, next_blocked, wd_armed, next_wd_armed, wd_fire;
	hmt_pkg::hmt_tstate_t tstate, next_tstate;
	logic [23:0] tcnt, next_tcnt, t1_load, long_load;
	logic [2:0] dclk_sync, wake_sync, retry, next_retry, cnt;
	logic poll, timer_expiry_irq, next_abort, next_discard, next_accept, next_own;
	logic [WW-1:0] wcnt, next_wcnt;
	logic mode_wr, timer_wr, term_wr, sti_wr, ext_rd, stat_rd;
	logic timer_mode_select, terminal_functions_enable, auto_md, dclk_edge, wake_fall, svc_hit;
	hmt_pkg::hmt_fmode_t fmode;
	function automatic logic ep_hit(input logic [7:0] b, hmt_pkg::hmt_ids_t d);
		ep_hit = b == d.endpoint_id_first || b == d.endpoint_id_second ||
			b == hmt_pkg::EP_GROUP;
	endfunction
	function automatic logic sv_eq(input logic [7:0] a, input logic [7:0] b);
		sv_eq = (a & hmt_pkg::SVC_MASK) == (b & hmt_pkg::SVC_MASK);
	endfunction
	assign svc_hit = sv_eq(i_addr_hi, i_ids.service_id_first) ||
		sv_eq(i_addr_hi, i_ids.service_id_second) ||
		sv_eq(i_addr_hi, hmt_pkg::SVC_GROUP);
	assign mode_wr = i_wr && i_addr == hmt_pkg::ADDR_MODE;
	assign timer_wr = i_wr && i_addr == hmt_pkg::ADDR_TIMER;
	assign term_wr = i_wr && i_addr == hmt_pkg::ADDR_TERM;
	assign sti_wr = i_wr && i_addr == hmt_pkg::ADDR_CMD &&
		i_wdata[hmt_pkg::CMD_STI];
	assign ext_rd = i_rd && i_addr == hmt_pkg::ADDR_EXT;
	assign stat_rd = i_rd && i_addr == hmt_pkg::ADDR_STATUS;
	assign fmode = hmt_pkg::hmt_fmode_t'(
		mode_reg[hmt_pkg::MODE_FMS_HI:hmt_pkg::MODE_FMS_LO]);
	assign timer_mode_select = mode_reg[hmt_pkg::MODE_TMD];
	assign auto_md = fmode == hmt_pkg::FM_AUTO1 || fmode == hmt_pkg::FM_AUTO2;
	assign terminal_functions_enable = term_reg[hmt_pkg::TERM_TSF];
	assign cnt = timer_reg[hmt_pkg::TIM_CNT_HI:hmt_pkg::TIM_CNT_LO];
	// The second and third stages feed the edge detectors
	assign dclk_edge = dclk_sync[1] && !dclk_sync[2];
	assign wake_fall = !wake_sync[1] && wake_sync[2];
	assign o_rx_enable = mode_reg[hmt_pkg::MODE_RAC];
	assign o_auto_mode = auto_md;
	assign o_tx_blocked = blocked;
	assign o_extended_summary_flag = summary;
	always_comb begin
		t1_load = 24'(term_reg[hmt_pkg::TERM_TLP] ? hmt_pkg::TEST_UNIT_DCLK
			: NORMAL_DCLK) * 24'(timer_reg[hmt_pkg::TIM_VAL_HI:0] + 6'h01);
		long_load = 24'(hmt_pkg::EXT_UNIT_DCLK) * 24'(cnt);
	end
	always_comb begin
		next_mode = mode_wr ? i_wdata : mode_reg;
		next_timer = timer_wr ? i_wdata : timer_reg;
		next_term = term_wr ? i_wdata : term_reg;
		next_rdata = o_rdata;
		if (i_rd) begin
			unique case (i_addr)
				hmt_pkg::ADDR_MODE: next_rdata = mode_reg;
				hmt_pkg::ADDR_TIMER: next_rdata = timer_reg;
				hmt_pkg::ADDR_EXT: next_rdata = ext_flags;
				hmt_pkg::ADDR_TERM: next_rdata = term_reg;
				hmt_pkg::ADDR_STATUS: begin
					next_rdata = 8'h00;
					next_rdata[hmt_pkg::STAT_TIN] = tin_flag;
					next_rdata[hmt_pkg::STAT_EXI] = summary;
				end
				default: next_rdata = 8'h00;
			endcase
		end
	end
	always_comb begin
		next_tstate = tstate;
		next_tcnt = tcnt;
		next_retry = retry;
		poll = 1'b0;
		timer_expiry_irq = 1'b0;
		// Register write, or acknowledgement in internal mode, stops the timer
		if (timer_wr || (timer_mode_select && i_tx_ev.ack)) begin
			next_tstate = hmt_pkg::TM_IDLE;
		end else if (sti_wr && !timer_mode_select) begin
			// Long phase first unless count is 0 or 7
			next_retry = 3'h0;
			if (cnt != 3'h0 && cnt != hmt_pkg::CNT_UNLIMITED) begin
				next_tstate = hmt_pkg::TM_LONG;
				next_tcnt = long_load;
			end else begin
				next_tstate = hmt_pkg::TM_BASE;
				next_tcnt = t1_load;
			end
		end else if (timer_mode_select && (sti_wr || (auto_md &&
				(i_tx_ev.iframe_start || i_rx_ev.rnr)))) begin
			next_tstate = hmt_pkg::TM_BASE;
			next_tcnt = t1_load;
			next_retry = 3'h0;
		end else if (dclk_edge && tstate != hmt_pkg::TM_IDLE) begin
			if (tcnt > 24'h000001) begin
				next_tcnt = tcnt - 24'h000001;
			end else if (tstate == hmt_pkg::TM_LONG) begin
				next_tstate = hmt_pkg::TM_BASE;
				next_tcnt = t1_load;
			end else if (timer_mode_select) begin
				// Retry with poll, irq after the last one
				if (cnt == hmt_pkg::CNT_UNLIMITED || retry < cnt) begin
					poll = 1'b1;
					next_tcnt = t1_load;
					if (cnt != hmt_pkg::CNT_UNLIMITED) begin
						next_retry = retry + 3'h1;
					end
				end else begin
					timer_expiry_irq = 1'b1;
					next_tstate = hmt_pkg::TM_IDLE;
				end
			end else begin
				// Count 7 keeps firing each base period
				timer_expiry_irq = 1'b1;
				next_tcnt = t1_load;
				if (cnt != hmt_pkg::CNT_UNLIMITED) begin
					next_tstate = hmt_pkg::TM_IDLE;
				end
			end
		end
	end
	// Watchdog: kick is a write with a=1,b=0 followed by a=0,b=1
	always_comb begin
		next_wd_armed = wd_armed;
		next_wcnt = wcnt + WW'(1);
		wd_fire = 1'b0;
		if (term_wr && i_wdata[hmt_pkg::TERM_WDA] &&
				!i_wdata[hmt_pkg::TERM_WDB]) begin
			next_wd_armed = 1'b1;
		end else if (term_wr && wd_armed && !i_wdata[hmt_pkg::TERM_WDA] &&
				i_wdata[hmt_pkg::TERM_WDB]) begin
			next_wd_armed = 1'b0;
			next_wcnt = '0;
		end
		if (!terminal_functions_enable) begin
			next_wcnt = '0;
			next_wd_armed = 1'b0;
		end else if (wcnt == WW'(WDOG_CYCLES - 1)) begin
			wd_fire = 1'b1;
			next_wcnt = '0;
		end
	end
	// Sticky flags; a set in the clearing cycle survives
	always_comb begin
		flag_set = 8'h00;
		flag_set[hmt_pkg::EX_XMR] = (auto_md && i_tx_ev.nak) ||
			(i_tx_ev.collision &&
			i_tx_ev.byte_count >= hmt_pkg::COLLISION_BYTES);
		flag_set[hmt_pkg::EX_XDU] = i_tx_ev.underrun;
		flag_set[hmt_pkg::EX_PCE] = auto_md && (i_rx_ev.nr_bad ||
			i_rx_ev.s_info || i_rx_ev.i_not_cmd || i_rx_ev.s_undef);
		flag_set[hmt_pkg::EX_RFO] = i_rx_ev.frame_lost;
		flag_set[hmt_pkg::EX_SOV] = i_sync_transfer_overflow;
		flag_set[hmt_pkg::EX_MOS] = i_monitor_change;
		flag_set[hmt_pkg::EX_SAW] = terminal_functions_enable && wake_fall;
		flag_set[hmt_pkg::EX_WOV] = wd_fire;
		// Bit order follows the layout above
		next_flags = (ext_rd ? 8'h00 : ext_flags) | flag_set;
		next_summary = (summary && !ext_rd) || |flag_set;
		next_blocked = (blocked && !ext_rd) ||
			flag_set[hmt_pkg::EX_XMR] || flag_set[hmt_pkg::EX_XDU];
		next_tin_flag = (tin_flag && !stat_rd) || timer_expiry_irq;
		next_abort = i_tx_ev.underrun;
		next_discard = i_rx_ev.frame_lost;
	end
	always_comb begin
		next_accept = 1'b0;
		next_own = 1'b0;
		unique case (fmode)
			hmt_pkg::FM_AUTO1, hmt_pkg::FM_NAUTO1: begin
				next_accept = ep_hit(i_addr_hi, i_ids);
				next_own = fmode == hmt_pkg::FM_AUTO1 &&
					i_addr_hi == i_ids.endpoint_id_first;
			end
			hmt_pkg::FM_AUTO2, hmt_pkg::FM_NAUTO2: begin
				next_accept = ep_hit(i_addr_lo, i_ids) && svc_hit;
				next_own = fmode == hmt_pkg::FM_AUTO2 &&
					sv_eq(i_addr_hi, i_ids.service_id_first) &&
					i_addr_lo == i_ids.endpoint_id_first;
			end
			hmt_pkg::FM_TRANS1: next_accept = ep_hit(i_addr_lo, i_ids);
			hmt_pkg::FM_TRANS2: next_accept = 1'b1;
			hmt_pkg::FM_TRANS3: next_accept = svc_hit;
			hmt_pkg::FM_RSVD: next_accept = 1'b0;
		endcase
	end
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			mode_reg <= 8'h00;
			timer_reg <= 8'h00;
			term_reg <= 8'h00;
			ext_flags <= 8'h00;
			o_rdata <= 8'h00;
			summary <= 1'b0;
			blocked <= 1'b0;
			tin_flag <= 1'b0;
			dclk_sync <= 3'h0;
			wake_sync <= 3'h7;
			tstate <= hmt_pkg::TM_IDLE;
			tcnt <= 24'h000000;
			retry <= 3'h0;
			wcnt <= '0;
			wd_armed <= 1'b0;
			o_addr_accept <= 1'b0;
			o_addr_own <= 1'b0;
			o_send_abort <= 1'b0;
			o_discard_frame <= 1'b0;
			o_poll_cmd <= 1'b0;
			o_timer_expiry_irq <= 1'b0;
			o_wdog_reset <= 1'b0;
		end else begin
			mode_reg <= next_mode;
			timer_reg <= next_timer;
			term_reg <= next_term;
			ext_flags <= next_flags;
			o_rdata <= next_rdata;
			summary <= next_summary;
			blocked <= next_blocked;
			tin_flag <= next_tin_flag;
			dclk_sync <= {dclk_sync[1:0], i_data_clock};
			wake_sync <= {wake_sync[1:0], i_external_wake_pin};
			tstate <= next_tstate;
			tcnt <= next_tcnt;
			retry <= next_retry;
			wcnt <= next_wcnt;
			wd_armed <= next_wd_armed;
			o_addr_accept <= next_accept;
			o_addr_own <= next_own;
			o_send_abort <= next_abort;
			o_discard_frame <= next_discard;
			o_poll_cmd <= poll || (timer_mode_select && sti_wr);
			o_timer_expiry_irq <= timer_expiry_irq;
			o_wdog_reset <= wd_fire;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	chk_rx_gate_follow: assert property (mode_wr |=>
		o_rx_enable == $past(i_wdata[hmt_pkg::MODE_RAC]))
		else $error("receiver enable not following mode write");
	chk_underrun_abort: assert property (i_tx_ev.underrun |=>
		o_send_abort && ext_flags[hmt_pkg::EX_XDU] && o_tx_blocked)
		else $error("underrun not aborted and flagged");
	chk_block_until_read: assert property (o_tx_blocked && !ext_rd
		|=> o_tx_blocked) else $error("transmit block dropped early");
	chk_summary_set: assert property (|flag_set |=>
		o_extended_summary_flag ##0 ext_flags != 8'h00)
		else $error("summary bit not raised with flag");
	chk_timer_write_stop: assert property (timer_wr |=>
		tstate == hmt_pkg::TM_IDLE ##1 !o_timer_expiry_irq)
		else $error("timer still running after register write");
	chk_start_poll: assert property (sti_wr && timer_mode_select |=> o_poll_cmd)
		else $error("start command in internal mode sent no poll");
	chk_wake_flag: assert property (terminal_functions_enable && wake_fall |=>
		ext_flags[hmt_pkg::EX_SAW]) else $error("wake edge lost");
	chk_lost_discard: assert property (i_rx_ev.frame_lost |=>
		o_discard_frame && ext_flags[hmt_pkg::EX_RFO])
		else $error("lost frame not discarded and flagged");
	chk_group_endpoint: assert property (fmode == hmt_pkg::FM_TRANS1 &&
		i_addr_lo == hmt_pkg::EP_GROUP |=> o_addr_accept)
		else $error("group endpoint not accepted");
	chk_reserved_mode: assert property (fmode == hmt_pkg::FM_RSVD &&
		!mode_wr |=> !o_addr_accept) else $error("reserved mode accepted");
	cov_timer_irq: cover property (o_timer_expiry_irq);
	cov_retry_poll: cover property (poll ##[1:1000] o_timer_expiry_irq);
	cov_wdog_fire: cover property (o_wdog_reset);
endmodule

// >>> hmt_cpu.sv
`timescale 1ns/100ps
module hmt_cpu (
	input wire logic i_mclk,
	input wire logic [7:0] i_rdata,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'h0;
		o_rd = 1'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		#1;
		o_addr = a;
		o_wdata = d;
		o_wr = 1'h1;
		@(posedge i_mclk);
		#1;
		o_wr = 1'h0;
		// Idle bus never shows stale values
		o_addr = ~a;
		o_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		#1;
		o_addr = a;
		o_rd = 1'h1;
		@(posedge i_mclk);
		#1;
		o_rd = 1'h0;
		o_addr = ~a;
		@(posedge i_mclk);
		#1;
		d = i_rdata;
	endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
module tb_top;
	typedef struct packed {
		logic [3:0] src;
		logic [7:0] bc;
		logic [7:0] fl;
	} hmt_evrow_t;
	typedef struct packed {
		logic [2:0] m;
		logic [7:0] hi;
		logic [7:0] lo;
		logic acc;
		logic own;
	} hmt_adrow_t;
	logic mclk, resetn, dclk, wake, sync_transfer_overflow, monitor_change_flag, wr, rd;
	logic [7:0] addr, wdata, rdata, hi, lo, d, md;
	logic acc, own, auto, rxen, blk, abrt, disc, poll, irq, summ, wdo;
	logic [9:0] p;
	hmt_pkg::hmt_tx_ev_t tx;
	hmt_pkg::hmt_rx_ev_t rx;
	hmt_pkg::hmt_ids_t ids;
	int err_count, checks, dcnt, polls, irqs, wdr, mark, i0, p0, w0, n;
	hmt_evrow_t ev[12] = '{'{4'h0, 8'h00, 8'h80}, '{4'h1, 8'h20, 8'h80},
		'{4'h1, 8'h1f, 8'h00}, '{4'h2, 8'h00, 8'h40},
		'{4'h3, 8'h00, 8'h20}, '{4'h4, 8'h00, 8'h20},
		'{4'h5, 8'h00, 8'h20}, '{4'h6, 8'h00, 8'h20},
		'{4'h7, 8'h00, 8'h10}, '{4'h8, 8'h00, 8'h08},
		'{4'h9, 8'h00, 8'h04}, '{4'h0, 8'h00, 8'h80}};
	hmt_adrow_t ad[18] = '{'{3'h0, 8'h43, 8'h00, 1'h1, 1'h1},
		'{3'h0, 8'h45, 8'h00, 1'h1, 1'h0}, '{3'h0, 8'hff, 8'h00, 1'h1, 1'h0},
		'{3'h0, 8'h47, 8'h00, 1'h0, 1'h0}, '{3'h1, 8'h10, 8'h43, 1'h1, 1'h1},
		'{3'h1, 8'hfc, 8'h45, 1'h1, 1'h0}, '{3'h1, 8'hfe, 8'hff, 1'h1, 1'h0},
		'{3'h1, 8'h30, 8'h43, 1'h0, 1'h0}, '{3'h2, 8'h43, 8'h00, 1'h1, 1'h0},
		'{3'h3, 8'h20, 8'hff, 1'h1, 1'h0}, '{3'h3, 8'h20, 8'h47, 1'h0, 1'h0},
		'{3'h4, 8'h43, 8'h00, 1'h0, 1'h0}, '{3'h5, 8'h99, 8'h45, 1'h1, 1'h0},
		'{3'h5, 8'h10, 8'h47, 1'h0, 1'h0}, '{3'h6, 8'h00, 8'h00, 1'h1, 1'h0},
		'{3'h7, 8'hfe, 8'h00, 1'h1, 1'h0}, '{3'h7, 8'h33, 8'h43, 1'h0, 1'h0},
		'{3'h5, 8'h00, 8'hff, 1'h1, 1'h0}};
	always #2 mclk = ~mclk;
	initial begin
		dclk = 1'h0;
		#37.3;
		forever #80 dclk = ~dclk;
	end
	always @(posedge dclk) dcnt++;
	always @(posedge mclk) begin
		polls += int'(poll);
		irqs += int'(irq);
		wdr += int'(wdo);
	end
	hmt_ctrl #(.NORMAL_DCLK(4), .WDOG_CYCLES(64)) dut (.i_mclk(mclk),
		.i_resetn(resetn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_data_clock(dclk),
		.i_external_wake_pin(wake), .i_tx_ev(tx), .i_rx_ev(rx),
		.i_sync_transfer_overflow(sync_transfer_overflow), .i_monitor_change(monitor_change_flag),
		.i_ids(ids), .i_addr_hi(hi), .i_addr_lo(lo), .o_addr_accept(acc),
		.o_addr_own(own), .o_auto_mode(auto), .o_rx_enable(rxen),
		.o_tx_blocked(blk), .o_send_abort(abrt), .o_discard_frame(disc),
		.o_poll_cmd(poll), .o_timer_expiry_irq(irq),
		.o_extended_summary_flag(summ), .o_wdog_reset(wdo));
	hmt_cpu cpu (.i_mclk(mclk), .i_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	task automatic chk(input string s, input logic [15:0] e,
		input logic [15:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e,
		input string s);
		cpu.rd(a, d);
		chk(s, 16'(e), 16'(d));
	endtask
	// Aligned to a data clock edge so edge counts come out exact
	task automatic tstart(input int how);
		@(posedge dclk);
		repeat (10) @(posedge mclk);
		mark = dcnt;
		i0 = irqs;
		p0 = polls;
		if (how == 0) begin
			cpu.wr(hmt_pkg::ADDR_CMD, 8'h10);
		end else begin
			#1;
			tx.iframe_start = (how == 1);
			rx.rnr = (how == 2);
			@(posedge mclk);
			#1;
			tx = '0;
			rx = '0;
		end
	endtask
	task automatic wirq();
		int k;
		k = 0;
		i0 = irqs;
		while (irqs == i0 && k < 30000) begin
			@(posedge mclk);
			k++;
		end
		n = dcnt - mark;
		mark = dcnt;
	endtask
	task automatic quiet(input int e);
		i0 = irqs;
		repeat (e) @(posedge dclk);
		chk("no irq", 16'h0, 16'(irqs - i0));
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// About three and a half times the expected run length
	initial begin
		#400000;
		err_count++;
		wrap_up();
	end
	initial begin
		mclk = 1'h0;
		resetn = 1'h0;
		wake = 1'h1;
		tx = '0;
		rx = '0;
		sync_transfer_overflow = 1'h0;
		monitor_change_flag = 1'h0;
		hi = 8'h00;
		lo = 8'h00;
		ids = {8'h43, 8'h45, 8'h10, 8'h20};
		repeat (20) @(posedge mclk);
		#1;
		resetn = 1'h1;
		repeat (3) @(posedge mclk);
		rchk(hmt_pkg::ADDR_EXT, 8'h00, "flags");
		rchk(hmt_pkg::ADDR_TIMER, 8'h00, "timer");
		rchk(8'h3f, 8'h00, "unmapped");
		chk("auto", 16'h1, 16'(auto));
		$display("reset test done");
		foreach (ev[i]) begin
			p = 10'h001 << ev[i].src;
			@(posedge mclk);
			#1;
			tx = {1'h0, p[0], 1'h0, p[1], p[2], ev[i].bc};
			rx = {1'h0, p[3], p[4], p[5], p[6], p[7]};
			sync_transfer_overflow = p[8];
			monitor_change_flag = p[9];
			@(posedge mclk);
			#1;
			tx = '0;
			rx = '0;
			sync_transfer_overflow = 1'h0;
			monitor_change_flag = 1'h0;
			chk("abort", 16'(p[2]), 16'(abrt));
			chk("discard", 16'(p[7]), 16'(disc));
			@(posedge mclk);
			#1;
			chk("blocked", 16'(|ev[i].fl[7:6]), 16'(blk));
			cpu.rd(hmt_pkg::ADDR_STATUS, d);
			chk("status", 16'(|ev[i].fl), 16'(d));
			chk("summary", 16'(|ev[i].fl), 16'(summ));
			rchk(hmt_pkg::ADDR_EXT, ev[i].fl, "flags");
			chk("summary", 16'h0, 16'(summ));
			chk("blocked", 16'h0, 16'(blk));
		end
		$display("event test done");
		foreach (ad[i]) begin
			md = {ad[i].m, 1'h0, i[0], 3'h0};
			cpu.wr(hmt_pkg::ADDR_MODE, md);
			hi = ad[i].hi;
			lo = ad[i].lo;
			repeat (2) @(posedge mclk);
			#1;
			chk("accept", 16'(ad[i].acc), 16'(acc));
			chk("own", 16'(ad[i].own), 16'(own));
			chk("auto", 16'(ad[i].m[2:1] == 2'h0), 16'(auto));
			chk("rx enable", 16'(i[0]), 16'(rxen));
			rchk(hmt_pkg::ADDR_MODE, md, "mode");
		end
		$display("address test done");
		cpu.wr(hmt_pkg::ADDR_MODE, 8'h00);
		wake = 1'h0;
		repeat (6) @(posedge mclk);
		#1;
		wake = 1'h1;
		rchk(hmt_pkg::ADDR_EXT, 8'h00, "wake off");
		cpu.wr(hmt_pkg::ADDR_TERM, 8'h01);
		w0 = wdr;
		wake = 1'h0;
		repeat (6) @(posedge mclk);
		#1;
		wake = 1'h1;
		rchk(hmt_pkg::ADDR_EXT, 8'h02, "wake");
		repeat (5) begin
			cpu.wr(hmt_pkg::ADDR_TERM, 8'h05);
			cpu.wr(hmt_pkg::ADDR_TERM, 8'h09);
			repeat (20) @(posedge mclk);
		end
		chk("kicked", 16'h0, 16'(wdr - w0));
		n = 0;
		while (wdr == w0 && n < 200) begin
			@(posedge mclk);
			n++;
		end
		chk("wdog pulse", 16'h1, 16'(wdr - w0));
		rchk(hmt_pkg::ADDR_EXT, 8'h01, "wdog flag");
		cpu.wr(hmt_pkg::ADDR_TERM, 8'h00);
		$display("terminal test done");
		cpu.wr(hmt_pkg::ADDR_TIMER, 8'h02);
		tstart(0);
		wirq();
		chk("period", 16'h000c, 16'(n));
		rchk(hmt_pkg::ADDR_STATUS, 8'h08, "timer bit");
		rchk(hmt_pkg::ADDR_STATUS, 8'h00, "timer bit clear");
		quiet(30);
		cpu.wr(hmt_pkg::ADDR_TIMER, 8'he0);
		tstart(0);
		wirq();
		chk("repeat", 16'h0004, 16'(n));
		wirq();
		chk("repeat", 16'h0004, 16'(n));
		cpu.wr(hmt_pkg::ADDR_TIMER, 8'he0);
		quiet(20);
		cpu.wr(hmt_pkg::ADDR_TERM, 8'h02);
		cpu.wr(hmt_pkg::ADDR_TIMER, 8'h00);
		tstart(0);
		wirq();
		chk("test period", 16'h0200, 16'(n));
		cpu.wr(hmt_pkg::ADDR_TERM, 8'h00);
		cpu.wr(hmt_pkg::ADDR_TIMER, 8'h20);
		tstart(0);
		quiet(20);
		cpu.wr(hmt_pkg::ADDR_TIMER, 8'h00);
		$display("external timer test done");
		cpu.wr(hmt_pkg::ADDR_MODE, 8'h10);
		cpu.wr(hmt_pkg::ADDR_TIMER, 8'h40);
		tstart(0);
		wirq();
		chk("retries", 16'h000c, 16'(n));
		chk("polls", 16'h3, 16'(polls - p0));
		tstart(2);
		wirq();
		chk("rnr start", 16'h000c, 16'(n));
		tstart(1);
		repeat (6) @(posedge dclk);
		@(posedge mclk);
		#1;
		tx.ack = 1'h1;
		@(posedge mclk);
		#1;
		tx.ack = 1'h0;
		quiet(20);
		chk("polls", 16'h1, 16'(polls - p0));
		cpu.wr(hmt_pkg::ADDR_TIMER, 8'he0);
		tstart(0);
		repeat (36) @(posedge dclk);
		chk("no irq", 16'h0, 16'(irqs - i0));
		chk("polls", 16'h9, 16'(polls - p0));
		cpu.wr(hmt_pkg::ADDR_TIMER, 8'h00);
		$display("internal timer test done");
		wrap_up();
	end
endmodule
